/* File: bench/mpc_load_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Pulled-up loads on the open drain pins
// ****************************************************************
module mpc_load_model
    import mpc_pkg::*;
#(
    parameter int NCH = 8
) (
    input  wire logic                 clk_sys,
    input  wire logic [NCH-1:0]       pwm_out,
    input  wire logic [NCH-1:0]       od_out,
    input  wire logic [NCH-1:0]       od_oe_n,
    output logic      [NCH-1:0]       pad,
    output logic      [NCH-1:0][8:0]  high_len,
    output logic      [8:0]           period0
);
    logic [NCH-1:0][8:0] run;
    logic [8:0]          since;
    logic                last0;

    // A released pin reads high through the pull-up, never the last driven level.
    assign pad = od_oe_n | od_out;

    always_ff @(posedge clk_sys) begin
        last0 <= pwm_out[0];
        since <= (pwm_out[0] && !last0) ? 9'h001 : since + 9'h001;
        if (pwm_out[0] && !last0) begin
            period0 <= since;
        end
        for (int i = 0; i < NCH; i++) begin
            run[i] <= pad[i] ? run[i] + 9'h001 : 9'h000;
            if (!pad[i] && run[i] != 9'h000) begin
                high_len[i] <= run[i];
            end
        end
    end
endmodule : mpc_load_model

`default_nettype wire

/* File: bench/mpc_pwm_controller_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
`include "mpc_regs.svh"

// ****************************************************************
// Port checker
// ****************************************************************
module mpc_pwm_controller_monitor
    import mpc_pkg::*;
#(
    parameter int NCH = 32
) (
    input  wire logic                     clk_sys,
    input  wire logic                     rst,
    input  wire logic                     enable,
    input  wire logic                     timebase_clear_bit,
    input  wire logic [`MPC_CNT_W-1:0]    top_value_reg,
    input  wire logic [`MPC_SPREAD_W-1:0] spread,
    input  wire logic                     is_write,
    input  wire logic                     im_write,
    input  wire logic                     overflow_clear,
    input  wire logic [NCH-1:0]           pwm_out,
    input  wire logic [NCH-1:0]           open_drain_pwm_out,
    input  wire logic [NCH-1:0]           open_drain_pwm_oe_n,
    input  wire logic                     match_event,
    input  wire logic                     overflow_irq,
    input  wire logic                     busy,
    input  wire logic [`MPC_CNT_W-1:0]    timebase_counter
);
    logic wrap;
    logic run;

    // Only the unspread top is modelled; with spread set these stay quiet.
    assign wrap = enable && !timebase_clear_bit && spread == 0 && timebase_counter >= top_value_reg;
    assign run = enable && !timebase_clear_bit && spread == 0 && timebase_counter < top_value_reg;

    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);

    wrap_zero_a: assert property (wrap |=> timebase_counter == 8'h00)
        else $error("counter did not restart after top");
    count_up_a: assert property (run |=> timebase_counter == $past(timebase_counter) + 8'h01)
        else $error("counter did not step by one");
    clear_zero_a: assert property (timebase_clear_bit |=> timebase_counter == 8'h00)
        else $error("clear did not zero the counter");
    idle_hold_a: assert property (!enable |=> timebase_counter == 8'h00)
        else $error("counter moved while disabled");
    ovf_set_a: assert property (wrap |=> overflow_irq)
        else $error("overflow not flagged on wrap");
    ovf_clear_a: assert property (overflow_clear && !enable |=> !overflow_irq)
        else $error("overflow flag not cleared");
    busy_take_a: assert property (!busy && (is_write || im_write) |=> busy)
        else $error("busy not raised by update");
    busy_hold_a: assert property (busy && run |=> busy)
        else $error("busy dropped before top");
    busy_drop_a: assert property (busy && wrap |=> !busy)
        else $error("busy still set after apply");
    od_mirror_a: assert property (open_drain_pwm_oe_n == pwm_out && open_drain_pwm_out == '0)
        else $error("open drain pin does not follow waveform");

    cover property (busy && wrap);
    cover property (match_event);
    cover property (timebase_clear_bit && timebase_counter != 8'h00);
endmodule : mpc_pwm_controller_monitor

bind mpc_pwm_controller mpc_pwm_controller_monitor #(.NCH(NCH)) i_mon (
    .clk_sys(clk_sys), .rst(rst), .enable(enable), .timebase_clear_bit(timebase_clear_bit),
    .top_value_reg(top_value_reg), .spread(spread), .is_write(is_write), .im_write(im_write),
    .overflow_clear(overflow_clear), .pwm_out(pwm_out), .open_drain_pwm_out(open_drain_pwm_out),
    .open_drain_pwm_oe_n(open_drain_pwm_oe_n), .match_event(match_event),
    .overflow_irq(overflow_irq), .busy(busy), .timebase_counter(timebase_counter));

`default_nettype wire

/* File: bench/mpc_pwm_controller_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module mpc_pwm_controller_tb
    import mpc_pkg::*;
;
    localparam int NCH = 8;
    typedef struct packed {logic [7:0] top; mpc_duty_t duty; logic [8:0] hi; logic [8:0] per;} mpc_row_s;
    mpc_row_s rows [5] = '{'{8'h0f, 8'h01, 9'h002, 9'h010}, '{8'h20, 8'h1f, 9'h020, 9'h021},
        '{8'h03, 8'h02, 9'h003, 9'h004}, '{8'h40, 8'h10, 9'h011, 9'h041},
        '{8'h0f, 8'h05, 9'h006, 9'h010}};
    logic clk_sys = 1'b0, rst = 1'b1, enable = 1'b0, timebase_clear_bit = 1'b0;
    logic is_write = 1'b0, im_write = 1'b0, overflow_clear = 1'b0;
    logic [7:0] top_value_reg = 8'h0f, is_chset = 8'h00, evt_up = 8'h00, evt_dn = 8'h00;
    mpc_duty_t is_duty = 8'h00;
    logic [3:0] composite_en = 4'h0;
    logic [31:0] im_duty = 32'h0000_0000;
    logic [19:0] im_sel = 20'h0_0000;
    logic [7:0] pwm_out, od_out, od_oe_n, pad, timebase_counter;
    logic match_event, overflow_irq, busy;
    logic [7:0][8:0] high_len;
    logic [8:0] period0;
    int fail_count = 0;
    int compares = 0;

    always #4 clk_sys = ~clk_sys;

    mpc_pwm_controller #(.NCH(NCH)) i_dut (
        .clk_sys(clk_sys), .rst(rst), .enable(enable), .timebase_clear_bit(timebase_clear_bit),
        .top_value_reg(top_value_reg), .spread(8'h00), .composite_en(composite_en),
        .is_write(is_write), .is_duty(is_duty), .is_chset(is_chset), .im_write(im_write),
        .im_duty(im_duty), .im_sel(im_sel), .evt_increase(evt_up), .evt_decrease(evt_dn),
        .overflow_clear(overflow_clear), .pwm_out(pwm_out), .open_drain_pwm_out(od_out),
        .open_drain_pwm_oe_n(od_oe_n), .match_event(match_event), .overflow_irq(overflow_irq),
        .busy(busy), .timebase_counter(timebase_counter));

    mpc_load_model #(.NCH(NCH)) i_load (.clk_sys(clk_sys), .pwm_out(pwm_out), .od_out(od_out),
        .od_oe_n(od_oe_n), .pad(pad), .high_len(high_len), .period0(period0));

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : tick

    task automatic wait_until(input logic want_busy, input logic [7:0] cnt);
        for (int i = 0; i < 600; i++) begin
            @(posedge clk_sys);
            #1;
            if (want_busy ? busy === 1'b0 : timebase_counter === cnt) return;
        end
        fail_count++;
        $display("Error at %0t: wait limit ran out", $time);
    endtask : wait_until

    task automatic req(input mpc_duty_t d, input logic [7:0] m);
        @(posedge clk_sys);
        is_write <= 1'b1;
        is_duty <= d;
        is_chset <= m;
        @(posedge clk_sys);
        is_write <= 1'b0;
    endtask : req

    task automatic evt(input logic up, input int ch);
        @(posedge clk_sys);
        if (up) evt_up[ch] <= 1'b1;
        else evt_dn[ch] <= 1'b1;
        @(posedge clk_sys);
        evt_up <= 8'h00;
        evt_dn <= 8'h00;
    endtask : evt

    task automatic report_and_stop;
        $display("Comparisons %0d, mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : report_and_stop

    // ****************************************************************
    // Sequence
    // ****************************************************************
    initial begin
        logic acc;
        int n;
        tick(9);
        #1;
        chk({1'b0, pwm_out | od_out}, 9'h000);
        chk({1'b0, timebase_counter}, 9'h000);
        chk({6'h00, busy, overflow_irq, match_event}, 9'h000);
        @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        enable <= 1'b1;
        foreach (rows[r]) begin
            @(posedge clk_sys);
            top_value_reg <= rows[r].top;
            req(rows[r].duty, 8'hff);
            wait_until(1'b1, 8'h00);
            tick(3 * (rows[r].top + 1) + 8);
            chk(high_len[0], rows[r].hi);
            chk(high_len[5], rows[r].hi);
            chk(period0, rows[r].per);
        end
        // The second write lands while the first is still waiting for the wrap.
        wait_until(1'b0, 8'h01);
        req(8'h09, 8'h01);
        tick(2);
        #1;
        chk({8'h00, busy}, 9'h001);
        req(8'h02, 8'h01);
        wait_until(1'b1, 8'h00);
        tick(56);
        chk(high_len[0], 9'h00a);
        evt(1'b1, 0);
        tick(56);
        chk(high_len[0], 9'h00b);
        req(8'h00, 8'h04);
        wait_until(1'b1, 8'h00);
        evt(1'b0, 2);
        acc = 1'b0;
        repeat (40) begin
            @(posedge clk_sys);
            #1;
            acc = acc | pwm_out[2];
        end
        chk({8'h00, acc}, 9'h000);
        @(posedge clk_sys);
        im_write <= 1'b1;
        im_duty <= {8'h04, 8'h09, 8'h06, 8'h07};
        im_sel <= {5'h01, 5'h1f, 5'h02, 5'h01};
        @(posedge clk_sys);
        im_write <= 1'b0;
        wait_until(1'b1, 8'h00);
        tick(56);
        chk(high_len[1], 9'h005);
        chk(high_len[2], 9'h007);
        chk(high_len[3], 9'h006);
        chk(high_len[0], 9'h00b);
        composite_en <= 4'h1;
        tick(56);
        chk(high_len[0], 9'h006);
        chk(high_len[1], 9'h00a);
        composite_en <= 4'h0;
        n = 0;
        repeat (16) begin
            @(posedge clk_sys);
            #1;
            n = n + int'(match_event);
        end
        chk(n[8:0], 9'h001);
        chk({8'h00, overflow_irq}, 9'h001);
        @(posedge clk_sys);
        enable <= 1'b0;
        overflow_clear <= 1'b1;
        @(posedge clk_sys);
        overflow_clear <= 1'b0;
        #1;
        chk({overflow_irq, timebase_counter}, 9'h000);
        @(posedge clk_sys);
        enable <= 1'b1;
        tick(6);
        timebase_clear_bit <= 1'b1;
        @(posedge clk_sys);
        timebase_clear_bit <= 1'b0;
        #1;
        chk({1'b0, timebase_counter}, 9'h000);
        report_and_stop;
    end

    // The sequence needs about a thousand cycles; this is a generous margin.
    initial begin
        tick(20000);
        fail_count++;
        report_and_stop;
    end
endmodule : mpc_pwm_controller_tb

`default_nettype wire

/* File: rtl/mpc_channel.sv */
`timescale 1ns/1ps
`default_nettype none
`include "mpc_regs.svh"

module mpc_channel
    import mpc_pkg::*;
#(
    parameter bit EVT_EN = 1'b1
) (
    input  wire logic                  clk_sys,
    input  wire logic                  rst,
    input  wire logic [`MPC_CNT_W-1:0] count,
    input  wire logic                  load,
    input  wire mpc_duty_t             load_val,
    input  wire logic                  step_up,
    input  wire logic                  step_down,
    output mpc_duty_t                  duty,
    output logic                       wave
);

    mpc_duty_t next_duty;
    logic      next_wave;

    always_comb begin
        next_duty = duty;
        if (load) begin
            next_duty = load_val;
        end else if (EVT_EN && step_up && !step_down && duty != `MPC_CNT_MAX) begin
            next_duty = duty + 8'h01;
        end else if (EVT_EN && step_down && !step_up && duty != `MPC_RST_DUTY) begin
            next_duty = duty - 8'h01;
        end
        // Left-aligned, non-inverted compare against the shared count.
        next_wave = (duty != `MPC_RST_DUTY) && (count <= duty);
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            duty <= `MPC_RST_DUTY;
            wave <= 1'b0;
        end else begin
            duty <= next_duty;
            wave <= next_wave;
        end
    end

endmodule : mpc_channel

`default_nettype wire

/* File: rtl/mpc_pwm_controller.sv */
`timescale 1ns/1ps
`default_nettype none
`include "mpc_regs.svh"

// What this block does
// - Each channel drives an 8-bit left-aligned non-inverted waveform on its own line.
// - One shared 8-bit timebase counter sets the period of all channels.
// - Every channel keeps its own 8-bit duty value compared against the counter.
// - Single-value update loads one duty into any chosen channels together.
// - Multi-value update loads four duties into four selected channels together.
// - Duty changes are staged and handed over without glitching the outputs.
// - Increase or decrease events move a channel's duty by exactly one.
// - A match event fires when the counter equals channel 0's duty.
// - An interrupt is raised when the counter wraps past its effective top.
// - Composite mode XORs each channel pair onto the pair's even output, its inverse onto the odd.
// - On enable the counter runs from zero to effective top, then restarts.
// - With spread zero the effective top equals the programmed top.
// - The clear bit resets the counter at once, glitches allowed.
// - Without clocks the block holds state and resumes when clocks return.
// - Processor debug halt does not stop the counter or outputs.
// - Output low for duty zero or count above duty, else high.
// - New duties apply at top, or at once while disabled; busy stays set until then.
// - Updates arriving while busy are dropped.
module mpc_pwm_controller
    import mpc_pkg::*;
#(
    parameter int                NCH     = 32,
    parameter logic [NCH-1:0]    EVT_MASK = '1
) (
    input  wire logic                                 clk_sys,
    input  wire logic                                 rst,
    input  wire logic                                 enable,
    input  wire logic                                 timebase_clear_bit,
    input  wire logic [`MPC_CNT_W-1:0]                top_value_reg,
    input  wire logic [`MPC_SPREAD_W-1:0]             spread,
    input  wire logic [NCH/2-1:0]                     composite_en,
    input  wire logic                                 is_write,
    input  wire mpc_duty_t                            is_duty,
    input  wire logic [NCH-1:0]                       is_chset,
    input  wire logic                                 im_write,
    input  wire logic [`MPC_IM_SLOTS*8-1:0]           im_duty,
    input  wire logic [`MPC_IM_SLOTS*`MPC_SEL_W-1:0]  im_sel,
    input  wire logic [NCH-1:0]                       evt_increase,
    input  wire logic [NCH-1:0]                       evt_decrease,
    input  wire logic                                 overflow_clear,
    output logic [NCH-1:0]                            pwm_out,
    output logic [NCH-1:0]                            open_drain_pwm_out,
    output logic [NCH-1:0]                            open_drain_pwm_oe_n,
    output logic                                      match_event,
    output logic                                      overflow_irq,
    output logic                                      busy,
    output logic [`MPC_CNT_W-1:0]                     timebase_counter
);

    // ****************************************************************
    // Timebase and spread counters
    // ****************************************************************
    logic signed [9:0]       sprd;
    logic signed [9:0]       next_sprd;
    logic [`MPC_CNT_W-1:0]   next_cnt;
    logic signed [9:0]       sprd_lo;
    logic signed [9:0]       sprd_hi;
    logic signed [9:0]       sprd_eff;
    logic signed [9:0]       etv_wide;
    logic [`MPC_CNT_W-1:0]   effective_top_value;
    logic                    wrap;
    logic                    next_overflow;
    logic                    next_match;

    // ****************************************************************
    // Spread limits
    // ****************************************************************
    // The spread range is clamped so the effective top never leaves 0..255.
    always_comb begin
        if ({2'b00, spread} > {2'b00, top_value_reg}) begin
            sprd_lo = -$signed({2'b00, top_value_reg});
        end else begin
            sprd_lo = -$signed({2'b00, spread});
        end
        if ({2'b00, spread} > {2'b00, `MPC_CNT_MAX} - {2'b00, top_value_reg}) begin
            sprd_hi = $signed({2'b00, `MPC_CNT_MAX} - {2'b00, top_value_reg});
        end else begin
            sprd_hi = $signed({2'b00, spread});
        end
        if (sprd < sprd_lo) begin
            sprd_eff = sprd_lo;
        end else if (sprd > sprd_hi) begin
            sprd_eff = sprd_hi;
        end else begin
            sprd_eff = sprd;
        end
        etv_wide            = $signed({2'b00, top_value_reg}) + sprd_eff;
        effective_top_value = etv_wide[`MPC_CNT_W-1:0];
    end

    // ****************************************************************
    // Timebase counter
    // ****************************************************************
    // Comparing with >= lets a top lowered below the running count wrap
    // at once instead of running on to 255 first.
    assign wrap = enable && !timebase_clear_bit && (timebase_counter >= effective_top_value);

    always_comb begin
        next_cnt  = timebase_counter;
        next_sprd = sprd;
        if (!enable) begin
            // Held at zero while disabled so enabling starts a clean period.
            next_cnt  = `MPC_RST_CNT;
            next_sprd = sprd_lo;
        end else if (timebase_clear_bit) begin
            next_cnt  = `MPC_RST_CNT;
            next_sprd = sprd_lo;
        end else if (wrap) begin
            next_cnt = `MPC_RST_CNT;
            if (sprd_eff >= sprd_hi) begin
                next_sprd = sprd_lo;
            end else begin
                next_sprd = sprd_eff + 10'sd1;
            end
        end else begin
            next_cnt = timebase_counter + 8'h01;
        end
    end

    // Nothing here can stop the clock or listen to a processor halt: a
    // stopped clock simply freezes every register, and counting picks up
    // where it left off once the clock returns.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            timebase_counter <= `MPC_RST_CNT;
            sprd             <= 10'sd0;
        end else begin
            timebase_counter <= next_cnt;
            sprd             <= next_sprd;
        end
    end

    // ****************************************************************
    // Staged duty updates
    // ****************************************************************
    mpc_upd_e              upd_state;
    mpc_upd_e              next_upd_state;
    logic [NCH-1:0]        pend_mask;
    logic [NCH-1:0]        next_pend_mask;
    // One staged value per channel lets a multi-value request carry four
    // different duties at once.
    mpc_duty_t             pend_val [NCH];
    mpc_duty_t             next_pend_val [NCH];
    logic                  apply;
    logic                  next_busy;
    mpc_duty_t             duty_q [NCH];
    logic [NCH-1:0]        wave;

    // Applying only at the wrap keeps every period whole; a disabled
    // counter never wraps, so staged values then go straight in.
    assign apply = (upd_state == MPC_UPD_WAIT) && (wrap || !enable);

    always_comb begin
        logic [`MPC_SEL_W-1:0] sel;
        sel            = '0;
        next_upd_state = upd_state;
        next_pend_mask = pend_mask;
        for (int c = 0; c < NCH; c++) begin
            next_pend_val[c] = pend_val[c];
        end
        case (upd_state)
            MPC_UPD_IDLE: begin
                // Only one request is taken per cycle; single-value wins.
                if (is_write) begin
                    next_pend_mask = is_chset;
                    for (int c = 0; c < NCH; c++) begin
                        next_pend_val[c] = is_duty;
                    end
                    next_upd_state = MPC_UPD_WAIT;
                end else if (im_write) begin
                    next_pend_mask = '0;
                    // Later slots overwrite earlier ones on a repeated channel.
                    // A select at or above NCH matches no channel, so that slot is dropped.
                    for (int s = 0; s < `MPC_IM_SLOTS; s++) begin
                        sel = im_sel[s*`MPC_SEL_W +: `MPC_SEL_W];
                        for (int c = 0; c < NCH; c++) begin
                            if (32'(sel) == c) begin
                                next_pend_mask[c] = 1'b1;
                                next_pend_val[c]  = im_duty[s*8 +: 8];
                            end
                        end
                    end
                    next_upd_state = MPC_UPD_WAIT;
                end
            end
            MPC_UPD_WAIT: begin
                // New requests are ignored here, whatever they carry.
                if (apply) begin
                    next_pend_mask = '0;
                    next_upd_state = MPC_UPD_IDLE;
                end
            end
            default: begin
                // A stray state drops whatever was staged rather than loading it.
                next_pend_mask = '0;
                next_upd_state = MPC_UPD_IDLE;
            end
        endcase
        next_busy = (next_upd_state == MPC_UPD_WAIT);
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            upd_state <= MPC_UPD_IDLE;
            pend_mask <= '0;
            busy      <= 1'b0;
            for (int c = 0; c < NCH; c++) begin
                pend_val[c] <= `MPC_RST_DUTY;
            end
        end else begin
            upd_state <= next_upd_state;
            pend_mask <= next_pend_mask;
            busy      <= next_busy;
            for (int c = 0; c < NCH; c++) begin
                pend_val[c] <= next_pend_val[c];
            end
        end
    end

    // ****************************************************************
    // Channels
    // ****************************************************************
    // Channels whose mask bit is clear never act on event pulses, so their
    // duty moves only by staged loads.
    for (genvar g = 0; g < NCH; g++) begin : gen_ch
        mpc_channel #(
            .EVT_EN (EVT_MASK[g])
        ) u_ch (
            .clk_sys   (clk_sys),
            .rst       (rst),
            .count     (timebase_counter),
            .load      (apply && pend_mask[g]),
            .load_val  (pend_val[g]),
            .step_up   (evt_increase[g]),
            .step_down (evt_decrease[g]),
            .duty      (duty_q[g]),
            .wave      (wave[g])
        );
    end

    // ****************************************************************
    // Status flags
    // ****************************************************************
    // The match pulse is held off while disabled, so a parked counter at
    // zero does not pulse every cycle against a zero duty on channel 0.
    always_comb begin
        // Software clears the sticky flag, but a wrap in the same cycle wins.
        next_overflow = wrap || (overflow_irq && !overflow_clear);
        next_match    = enable && (timebase_counter == duty_q[0]);
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            overflow_irq <= 1'b0;
            match_event  <= 1'b0;
        end else begin
            overflow_irq <= next_overflow;
            match_event  <= next_match;
        end
    end

    // ****************************************************************
    // Output stage
    // ****************************************************************
    logic [NCH-1:0] next_out;

    always_comb begin
        // In a composite pair the even line carries the XOR, the odd line its inverse.
        next_out = wave;
        for (int p = 0; p < NCH/2; p++) begin
            if (composite_en[p]) begin
                next_out[2*p]   = wave[2*p] ^ wave[2*p+1];
                next_out[2*p+1] = ~(wave[2*p] ^ wave[2*p+1]);
            end
        end
    end

    // The open-drain pin only ever pulls low, so its data stays zero and
    // the enable alone carries the waveform.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pwm_out             <= '0;
            open_drain_pwm_out  <= '0;
            open_drain_pwm_oe_n <= '0;
        end else begin
            pwm_out             <= next_out;
            open_drain_pwm_out  <= '0;
            open_drain_pwm_oe_n <= next_out;
        end
    end

endmodule : mpc_pwm_controller

`default_nettype wire

/* File: shared/mpc_pkg.sv */
`default_nettype none

package mpc_pkg;

    typedef logic [7:0] mpc_duty_t;

    typedef enum logic [0:0] {
        MPC_UPD_IDLE,
        MPC_UPD_WAIT
    } mpc_upd_e;

endpackage : mpc_pkg

`default_nettype wire

/* File: shared/mpc_regs.svh */
`ifndef MPC_REGS_SVH
`define MPC_REGS_SVH

// ****************************************************************
// Widths of the timebase and duty paths
// ****************************************************************
`define MPC_CNT_W        8
`define MPC_CNT_MAX      8'hff
`define MPC_SPREAD_W     8

// ****************************************************************
// Reset values
// ****************************************************************
`define MPC_RST_CNT      8'h00
`define MPC_RST_DUTY     8'h00
`define MPC_RST_TOP      8'hff

// ****************************************************************
// Multi-value update layout
// ****************************************************************
`define MPC_IM_SLOTS     4
`define MPC_SEL_W        5

`endif
